// File: rxfb_pkg.sv
// shared types and constants of the rf receive frame builder
package rxfb_pkg;

  // ==========================================================================
  // frame layout
  localparam logic [7:0] START_DELIM       = 8'h7E;
  localparam logic [7:0] TYPE_STD_RX       = 8'h90;
  localparam logic [7:0] TYPE_EXP_RX       = 8'h91;
  localparam logic [7:0] RESV_HI_VAL       = 8'hFF;
  localparam logic [7:0] RESV_LO_VAL       = 8'hFE;
  localparam logic [7:0] CSUM_BASE         = 8'hFF;
  localparam logic [9:0] OFF_DELIM         = 10'h000;
  localparam logic [9:0] OFF_LEN_HI        = 10'h001;
  localparam logic [9:0] OFF_LEN_LO        = 10'h002;
  localparam logic [9:0] OFF_TYPE          = 10'h003;
  localparam logic [9:0] OFF_ADDR_FIRST    = 10'h004;
  localparam logic [9:0] OFF_ADDR_LAST     = 10'h00B;
  localparam logic [9:0] OFF_RESV_HI       = 10'h00C;
  localparam logic [9:0] OFF_RESV_LO       = 10'h00D;
  localparam logic [9:0] OFF_STD_OPT       = 10'h00E;
  localparam logic [9:0] OFF_STD_DATA      = 10'h00F;
  localparam logic [9:0] OFF_EXP_SRC_EP    = 10'h00E;
  localparam logic [9:0] OFF_EXP_DST_EP    = 10'h00F;
  localparam logic [9:0] OFF_EXP_CLU_HI    = 10'h010;
  localparam logic [9:0] OFF_EXP_CLU_LO    = 10'h011;
  localparam logic [9:0] OFF_EXP_PRO_HI    = 10'h012;
  localparam logic [9:0] OFF_EXP_PRO_LO    = 10'h013;
  localparam logic [9:0] OFF_EXP_OPT       = 10'h014;
  localparam logic [9:0] OFF_EXP_DATA      = 10'h015;
  // frame data bytes ahead of the payload: type through options
  localparam logic [15:0] STD_HDR_LEN      = 16'h000C;
  localparam logic [15:0] EXP_HDR_LEN      = 16'h0012;

  // ==========================================================================
  // receive options bits
  localparam int OPT_ACK_BIT               = 0;
  localparam int OPT_BCAST_BIT             = 1;
  localparam int OPT_METHOD_LSB            = 6;
  localparam logic [1:0] METHOD_PTMP       = 2'h1;
  localparam logic [1:0] METHOD_DIRECTED   = 2'h2;
  localparam logic [1:0] METHOD_MESH       = 2'h3;

  // ==========================================================================
  // payload buffer
  localparam int PAY_AW                    = 8;
  localparam logic [8:0] PAY_MAX           = 9'h100;

  // ==========================================================================
  // register map and reset values
  localparam logic [3:0] REG_CTRL          = 4'h0;
  localparam logic [3:0] REG_STATUS        = 4'h1;
  localparam logic [3:0] REG_FRAMES        = 4'h2;
  localparam logic [3:0] REG_DROPS         = 4'h3;
  localparam logic [3:0] REG_LEN_LO        = 4'h4;
  localparam logic [3:0] REG_LEN_HI        = 4'h5;
  localparam int CTRL_FMT_BIT              = 0;
  localparam int STAT_BUSY_BIT             = 0;
  localparam int STAT_TRUNC_BIT            = 1;
  localparam logic CTRL_FMT_RESET          = 1'b0;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PREP, ST_SEND} rxfb_state_t;

  typedef struct packed {
    logic [63:0] src_addr;
    logic [7:0]  src_ep;
    logic [7:0]  dst_ep;
    logic [15:0] cluster;
    logic [15:0] profile;
    logic        plain_request;
    logic [7:0]  sender_src_ep;
    logic [7:0]  sender_dst_ep;
    logic [15:0] sender_cluster;
    logic        acked;
    logic        bcast;
    logic [1:0]  method;
  } rxfb_rx_hdr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } rxfb_rx_byte_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rxfb_tx_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rxfb_bus_req_t;

endpackage

// File: rxfb_payload_ram.sv
// payload buffer with registered read data
`timescale 1ns/10ps
module rxfb_payload_ram
  import rxfb_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_we,
  input  wire logic [PAY_AW-1:0] i_waddr,
  input  wire logic [7:0]        i_wdata,
  input  wire logic [PAY_AW-1:0] i_raddr,
  output logic      [7:0]        o_rdata
);

  logic [7:0] mem [0:(1<<PAY_AW)-1];

  // ==========================================================================
  // write port and registered read port
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

// File: rxfb_frame_builder.sv
// rf receive frame builder: stores a received packet and emits its api frame
// ============================================================================
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module rxfb_frame_builder
  import rxfb_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_rx_start,
  input  wire rxfb_rx_hdr_t  i_rx_hdr,
  input  wire rxfb_rx_byte_t i_rx_byte,
  output logic               o_rx_ready,
  output rxfb_tx_t           o_tx,
  input  wire logic          i_tx_ready,
  input  wire rxfb_bus_req_t i_bus,
  output logic      [7:0]    o_rd_data
);

  typedef struct packed {
    rxfb_state_t  st;
    logic         fmt_sel;
    logic         fmt_frame;
    rxfb_rx_hdr_t hdr;
    logic [8:0]   cnt;
    logic [9:0]   idx;
    logic [7:0]   csum;
    logic [7:0]   frames;
    logic [7:0]   drops;
    logic         trunc;
    logic [15:0]  last_len;
    logic         rx_ready;
    rxfb_tx_t     tx;
    logic [7:0]   rd_data;
  } rxfb_regs_t;

  localparam rxfb_regs_t REGS_RESET = '{
    st:        ST_IDLE,
    fmt_sel:   CTRL_FMT_RESET,
    fmt_frame: 1'b0,
    hdr:       '0,
    cnt:       9'h000,
    idx:       10'h000,
    csum:      8'h00,
    frames:    8'h00,
    drops:     8'h00,
    trunc:     1'b0,
    last_len:  16'h0000,
    rx_ready:  1'b1,
    tx:        '0,
    rd_data:   8'h00
  };

  rxfb_regs_t        s;
  rxfb_regs_t        next_s;
  logic [7:0]        pay_rdata;
  logic [PAY_AW-1:0] pay_raddr;
  logic              pay_we;
  logic [15:0]       frame_len;
  logic [9:0]        csum_idx;
  logic [9:0]        data_off;
  logic [7:0]        opt_byte;
  logic [7:0]        frame_byte;
  logic [9:0]        rd_off;
  logic [2:0]        addr_sel;
  logic              trunc_set;

  // ==========================================================================
  // payload buffer
  rxfb_payload_ram rxfb_payload_ram_i (
    .i_ref_clk (i_ref_clk),
    .i_we      (pay_we),
    .i_waddr   (s.cnt[PAY_AW-1:0]),
    .i_wdata   (i_rx_byte.data),
    .i_raddr   (pay_raddr),
    .o_rdata   (pay_rdata)
  );

  assign pay_we = (s.st == ST_LOAD) && i_rx_byte.valid && (s.cnt < PAY_MAX);

  // ==========================================================================
  // frame geometry
  always_comb begin
    if (s.fmt_frame) begin
      frame_len = EXP_HDR_LEN + {7'h00, s.cnt};
      data_off  = OFF_EXP_DATA;
    end else begin
      frame_len = STD_HDR_LEN + {7'h00, s.cnt};
      data_off  = OFF_STD_DATA;
    end
    csum_idx = OFF_TYPE + frame_len[9:0];
  end

  // fetch address tracks the index being loaded this edge
  always_comb begin
    rd_off    = next_s.idx - data_off;
    pay_raddr = rd_off[PAY_AW-1:0];
  end

  // ==========================================================================
  // receive options byte
  always_comb begin
    opt_byte                            = 8'h00;
    opt_byte[OPT_ACK_BIT]               = s.hdr.acked;
    opt_byte[OPT_BCAST_BIT]             = s.hdr.bcast;
    opt_byte[OPT_METHOD_LSB+1:OPT_METHOD_LSB] = s.hdr.method;
  end

  // ==========================================================================
  // byte at the current index
  always_comb begin
    addr_sel   = 3'(OFF_ADDR_LAST - s.idx);
    frame_byte = 8'h00;
    if (s.idx == OFF_DELIM) begin
      frame_byte = START_DELIM;
    end else if (s.idx == OFF_LEN_HI) begin
      frame_byte = frame_len[15:8];
    end else if (s.idx == OFF_LEN_LO) begin
      frame_byte = frame_len[7:0];
    end else if (s.idx == csum_idx) begin
      frame_byte = CSUM_BASE - s.csum;
    end else if (s.idx == OFF_TYPE) begin
      frame_byte = s.fmt_frame ? TYPE_EXP_RX : TYPE_STD_RX;
    end else if (s.idx <= OFF_ADDR_LAST) begin
      frame_byte = s.hdr.src_addr[addr_sel*8 +: 8];
    end else if (s.idx == OFF_RESV_HI) begin
      frame_byte = RESV_HI_VAL;
    end else if (s.idx == OFF_RESV_LO) begin
      frame_byte = RESV_LO_VAL;
    end else if (s.idx >= data_off) begin
      frame_byte = pay_rdata;
    end else if (!s.fmt_frame) begin
      frame_byte = opt_byte;
    end else begin
      case (s.idx)
        OFF_EXP_SRC_EP: begin
          frame_byte = s.hdr.src_ep;
        end
        OFF_EXP_DST_EP: begin
          frame_byte = s.hdr.dst_ep;
        end
        OFF_EXP_CLU_HI: begin
          frame_byte = s.hdr.cluster[15:8];
        end
        OFF_EXP_CLU_LO: begin
          frame_byte = s.hdr.cluster[7:0];
        end
        OFF_EXP_PRO_HI: begin
          frame_byte = s.hdr.profile[15:8];
        end
        OFF_EXP_PRO_LO: begin
          frame_byte = s.hdr.profile[7:0];
        end
        OFF_EXP_OPT: begin
          frame_byte = opt_byte;
        end
        default: begin
          frame_byte = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_s    = s;
    trunc_set = 1'b0;
    next_s.rd_data = 8'h00;

    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        REG_CTRL: begin
          next_s.fmt_sel = i_bus.wdata[CTRL_FMT_BIT];
        end
        REG_STATUS: begin
          if (i_bus.wdata[STAT_TRUNC_BIT]) begin
            next_s.trunc = 1'b0;
          end
        end
        default: begin
          next_s.fmt_sel = s.fmt_sel;
        end
      endcase
    end

    // register reads, data stand one cycle
    if (i_bus.rd) begin
      case (i_bus.addr)
        REG_CTRL: begin
          next_s.rd_data[CTRL_FMT_BIT] = s.fmt_sel;
        end
        REG_STATUS: begin
          next_s.rd_data[STAT_BUSY_BIT]  = (s.st != ST_IDLE);
          next_s.rd_data[STAT_TRUNC_BIT] = s.trunc;
        end
        REG_FRAMES: begin
          next_s.rd_data = s.frames;
        end
        REG_DROPS: begin
          next_s.rd_data = s.drops;
        end
        REG_LEN_LO: begin
          next_s.rd_data = s.last_len[7:0];
        end
        REG_LEN_HI: begin
          next_s.rd_data = s.last_len[15:8];
        end
        default: begin
          next_s.rd_data = 8'h00;
        end
      endcase
    end

    // start while a packet is in hand is dropped
    if (i_rx_start && (s.st != ST_IDLE)) begin
      next_s.drops = s.drops + 8'h01;
    end

    case (s.st)
      ST_IDLE: begin
        if (i_rx_start) begin
          next_s.hdr       = i_rx_hdr;
          next_s.fmt_frame = s.fmt_sel;
          if (i_rx_hdr.plain_request) begin
            next_s.hdr.src_ep  = i_rx_hdr.sender_src_ep;
            next_s.hdr.dst_ep  = i_rx_hdr.sender_dst_ep;
            next_s.hdr.cluster = i_rx_hdr.sender_cluster;
          end
          next_s.cnt = 9'h000;
          next_s.st  = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (i_rx_byte.valid) begin
          if (s.cnt < PAY_MAX) begin
            next_s.cnt = s.cnt + 9'h001;
          end else begin
            trunc_set = 1'b1;
          end
          if (i_rx_byte.last) begin
            next_s.idx      = OFF_DELIM;
            next_s.csum     = 8'h00;
            next_s.rx_ready = 1'b0;
            next_s.st       = ST_PREP;
          end
        end
      end
      ST_PREP: begin
        next_s.tx.valid = 1'b1;
        next_s.tx.data  = frame_byte;
        if ((s.idx >= OFF_TYPE) && (s.idx != csum_idx)) begin
          next_s.csum = s.csum + frame_byte;
        end
        next_s.st = ST_SEND;
      end
      ST_SEND: begin
        if (i_tx_ready) begin
          next_s.tx.valid = 1'b0;
          if (s.idx == csum_idx) begin
            next_s.frames   = s.frames + 8'h01;
            next_s.last_len = frame_len;
            next_s.rx_ready = 1'b1;
            next_s.st       = ST_IDLE;
          end else begin
            next_s.idx = s.idx + 10'h001;
            next_s.st  = ST_PREP;
          end
        end
      end
      default: begin
        next_s = REGS_RESET;
      end
    endcase

    // overflow flag: a new event beats a clear in the same cycle
    if (trunc_set) begin
      next_s.trunc = 1'b1;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s <= REGS_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign o_rx_ready = s.rx_ready;
  assign o_tx       = s.tx;
  assign o_rd_data  = s.rd_data;

endmodule

// File: rxfb_monitor.sv
// port assertions of the rf receive frame builder
`timescale 1ns/10ps
module rxfb_monitor
  import rxfb_pkg::*;
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_rx_start,
  input  wire rxfb_rx_byte_t i_rx_byte,
  input  wire logic          o_rx_ready,
  input  wire rxfb_tx_t      o_tx,
  input  wire logic          i_tx_ready,
  input  wire rxfb_bus_req_t i_bus,
  input  wire logic [7:0]    o_rd_data
);
  // ==========================================================================
  // helper state
  logic [9:0] idx;
  logic       fmt;
  logic       lfmt;
  logic       load;
  wire        acc = o_tx.valid && i_tx_ready;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idx  <= 10'h000;
      fmt  <= 1'b0;
      lfmt <= 1'b0;
      load <= 1'b0;
    end else begin
      if (o_rx_ready) idx <= 10'h000;
      else if (acc) idx <= idx + 10'h001;
      if (i_bus.wr && i_bus.addr == REG_CTRL) fmt <= i_bus.wdata[CTRL_FMT_BIT];
      if (i_rx_start && o_rx_ready && !load) begin
        load <= 1'b1;
        lfmt <= fmt;
      end else if (i_rx_byte.valid && i_rx_byte.last) begin
        load <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  // ==========================================================================
  // assertions
  a_hold_valid:
    assert property (o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data))
    else $error("tx byte changed before accept");
  a_gap_accept:
    assert property (acc |=> !o_tx.valid) else $error("no idle cycle after accept");
  a_delim_first:
    assert property (load && i_rx_byte.valid && i_rx_byte.last |-> ##2
      (o_tx.valid && o_tx.data == START_DELIM)) else $error("start delimiter late");
  a_busy_quiet:
    assert property (o_tx.valid |-> !o_rx_ready) else $error("ready while sending");
  a_type_code:
    assert property (acc && idx == OFF_TYPE |-> o_tx.data == (lfmt ? TYPE_EXP_RX : TYPE_STD_RX))
    else $error("wrong type byte");
  a_resv_pair:
    assert property (acc && (idx == OFF_RESV_HI || idx == OFF_RESV_LO) |->
      o_tx.data == (idx[0] ? RESV_LO_VAL : RESV_HI_VAL)) else $error("wrong reserved byte");
  a_opt_spare:
    assert property (acc && idx == (lfmt ? OFF_EXP_OPT : OFF_STD_OPT) |-> o_tx.data[5:2] == 4'h0)
    else $error("spare option bits set");
  a_rd_zero:
    assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00) else $error("read data not zero");
  a_ctrl_read:
    assert property (i_bus.rd && i_bus.addr == REG_CTRL |=> o_rd_data == {7'h00, fmt})
    else $error("format readback wrong");
endmodule

bind rxfb_frame_builder rxfb_monitor rxfb_monitor_i (
  .i_ref_clk  (i_ref_clk),
  .i_nrst     (i_nrst),
  .i_rx_start (i_rx_start),
  .i_rx_byte  (i_rx_byte),
  .o_rx_ready (o_rx_ready),
  .o_tx       (o_tx),
  .i_tx_ready (i_tx_ready),
  .i_bus      (i_bus),
  .o_rd_data  (o_rd_data)
);

// File: rxfb_host_model.sv
// host side model: takes frame bytes, stalls on request
`timescale 1ns/10ps
module rxfb_host_model
  import rxfb_pkg::*;
(
  input  wire logic     i_ref_clk,
  input  wire logic     i_nrst,
  input  wire logic     i_slow,
  input  wire rxfb_tx_t i_tx,
  output logic          o_tx_ready,
  output rxfb_tx_t      o_got
);
  logic [1:0] cnt;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt   <= 2'h0;
      o_got <= '0;
    end else begin
      cnt   <= cnt + 2'h1;
      o_got <= '{valid: i_tx.valid && o_tx_ready, data: i_tx.data};
    end
  end
  assign o_tx_ready = !i_slow || (cnt == 2'h3);
endmodule

// File: rxfb_frame_builder_test.sv
// testbench of the rf receive frame builder
`timescale 1ns/10ps
module rxfb_frame_builder_test
  import rxfb_pkg::*;
;
  logic          i_ref_clk = 1'b0;
  logic          i_nrst = 1'b0;
  logic          i_rx_start = 1'b0;
  rxfb_rx_hdr_t  hdr = '0;
  rxfb_rx_byte_t rxb = '0;
  rxfb_bus_req_t bus = '0;
  rxfb_tx_t      tx;
  rxfb_tx_t      got;
  logic          rdy;
  logic          rx_ready;
  logic          slow = 1'b0;
  logic          rd_q = 1'b0;
  logic          fmt = 1'b0;
  logic [7:0]    rd_data;
  logic [7:0]    q[$];
  logic [7:0]    rq[$];
  integer        seed = 32'h1740;
  integer        bad_count = 0;
  integer        check_count = 0;
  integer        drops = 0;
  integer        frames = 0;

  always #50 i_ref_clk = ~i_ref_clk;

  rxfb_frame_builder rxfb_frame_builder_i (
    .i_ref_clk (i_ref_clk), .i_nrst (i_nrst), .i_rx_start (i_rx_start), .i_rx_hdr (hdr),
    .i_rx_byte (rxb), .o_rx_ready (rx_ready), .o_tx (tx), .i_tx_ready (rdy),
    .i_bus (bus), .o_rd_data (rd_data));
  rxfb_host_model rxfb_host_model_i (
    .i_ref_clk (i_ref_clk), .i_nrst (i_nrst), .i_slow (slow), .i_tx (tx),
    .o_tx_ready (rdy), .o_got (got));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (q.size() != 0 || rq.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk) bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge i_ref_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk) bus.rd <= 1'b0;
  endtask

  task automatic pkt(input logic f, input logic [1:0] m, input int n, input logic pl,
                     input logic dr);
    logic [159:0] r;
    rxfb_rx_hdr_t h;
    logic [7:0]   fd[$];
    logic [7:0]   s;
    logic [15:0]  c;
    logic [15:0]  len;
    logic [7:0]   b;
    logic [7:0]   pay[$];
    if (f !== fmt) wr(REG_CTRL, {7'h00, f});
    fmt = f;
    r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    h = r[$bits(h)-1:0];
    h.method = m;
    h.plain_request = pl;
    c = pl ? h.sender_cluster : h.cluster;
    fd = {(f ? TYPE_EXP_RX : TYPE_STD_RX)};
    for (int i = 7; i >= 0; i--) fd.push_back(h.src_addr[8*i +: 8]);
    fd.push_back(RESV_HI_VAL);
    fd.push_back(RESV_LO_VAL);
    if (f) begin
      fd.push_back(pl ? h.sender_src_ep : h.src_ep);
      fd.push_back(pl ? h.sender_dst_ep : h.dst_ep);
      fd.push_back(c[15:8]);
      fd.push_back(c[7:0]);
      fd.push_back(h.profile[15:8]);
      fd.push_back(h.profile[7:0]);
    end
    fd.push_back({m, 4'h0, h.bcast, h.acked});
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      pay.push_back(b);
      if (i < PAY_MAX) fd.push_back(b);
    end
    len = 16'(fd.size());
    s = 8'h00;
    q.push_back(START_DELIM);
    q.push_back(len[15:8]);
    q.push_back(len[7:0]);
    foreach (fd[i]) begin
      q.push_back(fd[i]);
      s += fd[i];
    end
    q.push_back(CSUM_BASE - s);
    @(posedge i_ref_clk) begin
      i_rx_start <= 1'b1;
      hdr <= h;
    end
    foreach (pay[i]) begin
      @(posedge i_ref_clk) i_rx_start <= 1'b0;
      rxb <= '{valid: 1'b1, data: pay[i], last: i == pay.size() - 1};
    end
    @(posedge i_ref_clk) rxb <= '0;
    if (dr) begin
      for (int k = 0; k < 50 && rx_ready; k++) @(posedge i_ref_clk);
      i_rx_start <= 1'b1;
      rxb <= '{valid: 1'b1, data: 8'hA5, last: 1'b1};
      @(posedge i_ref_clk) i_rx_start <= 1'b0;
      rxb <= '0;
      drops++;
    end
    for (int k = 0; k < 3000 && !(q.size() == 0 && rx_ready); k++) @(posedge i_ref_clk);
    if (q.size() != 0 || !rx_ready) bad_count++;
    frames++;
  endtask

  // ==========================================================================
  // result watchers
  always @(posedge i_ref_clk) begin
    rd_q <= bus.rd;
    if (rd_q) check(rd_data, rq.size() ? rq.pop_front() : 8'hXX);
    if (got.valid) check(got.data, q.size() ? q.pop_front() : 8'hXX);
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    rd(REG_CTRL, 8'h00);
    rd(4'hF, 8'h00);
    for (int m = 0; m < 4; m++) pkt(1'b0, m[1:0], m + 1, 1'b0, 1'b0);
    slow <= 1'b1;
    pkt(1'b0, 2'h3, 40, 1'b0, 1'b0);
    pkt(1'b1, 2'h1, 6, 1'b0, 1'b1);
    slow <= 1'b0;
    rd(REG_STATUS, 8'h00);
    pkt(1'b0, 2'h1, 257, 1'b0, 1'b0);
    rd(REG_STATUS, 8'h02);
    wr(REG_STATUS, 8'h02);
    rd(REG_STATUS, 8'h00);
    pkt(1'b1, 2'h2, 1, 1'b1, 1'b0);
    rd(REG_CTRL, 8'h01);
    rd(REG_FRAMES, frames[7:0]);
    rd(REG_DROPS, drops[7:0]);
    rd(REG_LEN_LO, 8'h13);
    rd(REG_LEN_HI, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    print_verdict;
  end

  initial begin
    #(100 * 20000);
    bad_count++;
    print_verdict;
  end
endmodule
